// ---- hw/ruc_sync.sv ----
`timescale 1ns/1ps
module ruc_sync #(
   parameter int unsigned W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // The first stage feeds only the second stage.
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
               meta_ff[g] <= RST[g];
               sync_ff[g] <= RST[g];
            end else begin
               meta_ff[g] <= async_i[g];
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate

   assign sync_o = sync_ff;
endmodule

// ---- hw/ruc_upgrade_regs.sv ----
`timescale 1ns/1ps
module ruc_upgrade_regs (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   // Device pins and straps
   input  wire logic              external_config_reset_n_i,
   input  wire logic              config_error_line_n_i,
   input  wire logic              parallel_boot_scheme_i,
   input  wire logic              factory_boot_set_instr_i,
   input  wire logic [23:0]       factory_boot_addr_i,
   // Configuration engine
   input  wire logic              crc_error_i,
   input  wire logic              config_finished_pin_i,
   input  wire logic              early_done_i,
   input  wire logic              image_bad_i,
   // Fabric user logic
   input  wire ruc_pkg::ruc_shift_t shift_i,
   input  wire logic              fabric_reconfig_request_i,
   input  wire logic              watchdog_reload_strobe_i,
   // Outputs
   output logic                   shift_dout_o,
   output logic                   reconfig_o,
   output logic [23:0]            boot_addr_o,
   output logic                   startup_osc_sel_o,
   output logic                   early_check_o,
   output logic                   app_mode_o
);
   import ruc_pkg::*;

   ruc_regs_t   st_ff;
   ruc_regs_t   nxt_st;
   ruc_cause_t  cause;
   ruc_cause_t  win;
   logic [27:0] sync_s;
   logic        ext_s;
   logic        err_s;
   logic        par_s;
   logic        set_s;
   logic [23:0] addr_s;
   logic        tick;
   logic        dog_expire;
   logic [28:0] dog_load;
   logic [23:0] fact_boot;
   logic [1:0]  mstate;
   logic        strap_take;

   ruc_sync #(
      .W   (SYNC_W),
      .RST (SYNC_RST)
   ) u_sync (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .async_i ({factory_boot_addr_i, factory_boot_set_instr_i,
                 parallel_boot_scheme_i, config_error_line_n_i,
                 external_config_reset_n_i}),
      .sync_o  (sync_s)
   );

   assign ext_s  = sync_s[0];
   assign err_s  = sync_s[1];
   assign par_s  = sync_s[2];
   assign set_s  = sync_s[3];
   assign addr_s = sync_s[27:4];

   assign tick      = (st_ff.tick_cnt == 5'(TICK_DIV - 1));
   assign dog_load  = {st_ff.ctl.watchdog_timeout_field, DOG_LOW};
   assign fact_boot = st_ff.parallel ? st_ff.fact_addr : SERIAL_FACT;
   assign mstate    = (st_ff.state == ST_FACTORY) ? MS_FACTORY : MS_APP;
   // The synchroniser sits at its reset level during reset, so the strap is
   // only trusted once two edges have refilled it with the pin.
   assign strap_take = !st_ff.init && (st_ff.tick_cnt == STRAP_WAIT);
   // The watchdog only runs in application user mode.
   assign dog_expire = (st_ff.state == ST_USER) &&
                       st_ff.ctl.watchdog_enable && tick &&
                       (st_ff.dog_cnt == 29'h0) &&
                       !watchdog_reload_strobe_i;

   always_comb begin
      nxt_st          = st_ff;
      nxt_st.reconfig = 1'b0;
      nxt_st.ext_prev = ext_s;
      nxt_st.err_prev = err_s;
      nxt_st.set_prev = set_s;
      nxt_st.tick_cnt = tick ? 5'h00 : st_ff.tick_cnt + 5'h01;

      // Causes are edges on the pins, pulses from fabric and engine, or watchdog expiry.
      cause                     = '0;
      cause.ext_reset           = st_ff.ext_prev && !ext_s;
      cause.err_line            = st_ff.err_prev && !err_s;
      cause.crc                 = crc_error_i ||
                                  ((st_ff.state == ST_LOADING) &&
                                   st_ff.ctl.early_done_check_opt &&
                                   (image_bad_i || early_done_i));
      cause.watchdog_cause_flag = dog_expire;
      cause.fabric              = fabric_reconfig_request_i;

      win = '0;
      if (cause.ext_reset) begin
         win.ext_reset = 1'b1;
      end else if (cause.crc) begin
         win.crc = 1'b1;
      end else if (cause.err_line) begin
         win.err_line = 1'b1;
      end else if (cause.watchdog_cause_flag) begin
         win.watchdog_cause_flag = 1'b1;
      end else if (cause.fabric) begin
         win.fabric = 1'b1;
      end

      // A new factory address is taken once per instruction.
      if (set_s && !st_ff.set_prev) begin
         nxt_st.fact_addr = addr_s;
      end

      // Shift path: capture has priority over shifting.
      if (shift_i.capture) begin
         unique case (shift_i.sel)
            SEL_STATE: begin
               if (st_ff.state == ST_FACTORY) begin
                  nxt_st.sr = {7'h00, mstate, 6'h00,
                               st_ff.boot_addr};
               end else begin
                  nxt_st.sr = {7'h00, mstate,
                               st_ff.ctl.watchdog_enable,
                               dog_load};
               end
            end
            SEL_INFO2: nxt_st.sr = {7'h00, mstate, 6'h00,
                                    st_ff.boot_addr};
            SEL_HIST1: nxt_st.sr = st_ff.app_seen ?
                                   {8'h00, st_ff.hist1} :
                                   {7'h00, HIST_INVALID};
            SEL_HIST2: nxt_st.sr = st_ff.app_seen ?
                                   {8'h00, st_ff.hist2} :
                                   {7'h00, HIST_INVALID};
            SEL_CTL: nxt_st.sr = (st_ff.state == ST_FACTORY) ?
                                 st_ff.upd : st_ff.ctl;
            default: nxt_st.sr = '0;
         endcase
      end else if (shift_i.shift_en) begin
         nxt_st.sr = {st_ff.sr[37:0], shift_i.din};
      end
      if (shift_i.update && (st_ff.state == ST_FACTORY)) begin
         nxt_st.upd = st_ff.sr;
      end

      // Watchdog down-counter with reload.
      if ((st_ff.state == ST_USER) && st_ff.ctl.watchdog_enable) begin
         if (watchdog_reload_strobe_i) begin
            nxt_st.dog_cnt = dog_load;
         end else if (tick && (st_ff.dog_cnt != 29'h0)) begin
            nxt_st.dog_cnt = st_ff.dog_cnt - 29'h1;
         end
      end

      if (!st_ff.init) begin
         // Causes are ignored until the straps have been caught.
         if (strap_take) begin
            nxt_st.init     = 1'b1;
            nxt_st.parallel = par_s;
            nxt_st.ctl      = '0;
            nxt_st.state    = ST_FACTORY;
            if (par_s) begin
               nxt_st.ctl.boot_page_field = st_ff.fact_addr[23:2];
               nxt_st.boot_addr           = st_ff.fact_addr;
            end else begin
               nxt_st.boot_addr = SERIAL_FACT;
            end
         end
      end else if (|cause) begin
         nxt_st.hist2    = st_ff.hist1;
         nxt_st.hist1    = '{cause: win, mstate: mstate,
                             boot_addr: st_ff.boot_addr};
         nxt_st.reconfig = 1'b1;
         nxt_st.app_mode = 1'b0;
         if (win.fabric) begin
            // Control is loaded from the update register only here, by the state machine.
            nxt_st.ctl       = st_ff.upd;
            nxt_st.state     = ST_LOADING;
            nxt_st.boot_addr = {st_ff.upd.boot_page_field, 2'h0};
            nxt_st.osc_sel   = st_ff.upd.osc_opt;
            nxt_st.early_chk = st_ff.upd.early_done_check_opt;
         end else begin
            nxt_st.ctl       = '0;
            nxt_st.state     = ST_FACTORY;
            nxt_st.boot_addr = fact_boot;
            nxt_st.osc_sel   = 1'b0;
            nxt_st.early_chk = 1'b0;
         end
      end else if ((st_ff.state == ST_LOADING) && config_finished_pin_i) begin
         nxt_st.state     = ST_USER;
         nxt_st.app_seen  = 1'b1;
         nxt_st.app_mode  = 1'b1;
         nxt_st.dog_cnt   = dog_load;
         nxt_st.osc_sel   = 1'b0;
         nxt_st.early_chk = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_ff <= RUC_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign shift_dout_o      = st_ff.sr[38];
   assign reconfig_o        = st_ff.reconfig;
   assign boot_addr_o       = st_ff.boot_addr;
   assign startup_osc_sel_o = st_ff.osc_sel;
   assign early_check_o     = st_ff.early_chk;
   assign app_mode_o        = st_ff.app_mode;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   AST_SERIAL_ZERO: assert property (
      (strap_take && !par_s) |=>
         (st_ff.ctl == '0) && (boot_addr_o == 24'h000000))
      else $error("serial power-up address not zero");

   AST_PARALLEL_DEFAULT: assert property (
      (strap_take && par_s) |=>
         (boot_addr_o == $past(st_ff.fact_addr)) &&
         (st_ff.ctl.boot_page_field == $past(st_ff.fact_addr[23:2])))
      else $error("parallel power-up address wrong");

   AST_UPDATE_APP_BLOCKED: assert property (
      (shift_i.update && (st_ff.state != ST_FACTORY)) |=>
         $stable(st_ff.upd))
      else $error("update register written outside factory");

   AST_DOG_LOAD: assert property (
      ((st_ff.state == ST_LOADING) && config_finished_pin_i &&
       !(|cause)) |=>
         (st_ff.dog_cnt == {st_ff.ctl.watchdog_timeout_field, DOG_LOW}))
      else $error("watchdog count not formed from timeout");

   AST_BOOT_PAGE: assert property (
      (st_ff.state == ST_LOADING) |->
         (boot_addr_o == {st_ff.ctl.boot_page_field, 2'h0}))
      else $error("boot address not page with two zeros");

   AST_CAUSE_ONEHOT: assert property (
      reconfig_o |-> $onehot(st_ff.hist1.cause))
      else $error("history cause not one-hot");

   AST_PRIORITY: assert property (
      (st_ff.init && cause.ext_reset && cause.fabric) |=>
         (st_ff.hist1.cause == 5'h10) && (st_ff.ctl == '0))
      else $error("external reset did not win");

   AST_ERROR_CLEARS: assert property (
      (st_ff.init && (|cause) && !win.fabric) |=>
         (st_ff.ctl == '0) && (st_ff.state == ST_FACTORY) ##1
         (st_ff.state == ST_FACTORY))
      else $error("error did not clear control");

   AST_DOG_EXPIRE: assert property (
      (st_ff.init && dog_expire && !(|cause[4:2])) |=>
         reconfig_o && st_ff.hist1.cause.watchdog_cause_flag &&
         (st_ff.state == ST_FACTORY))
      else $error("watchdog expiry did not load factory");

   AST_INVALID_MARK: assert property (
      (shift_i.capture && (shift_i.sel == SEL_HIST1) && !st_ff.app_seen)
         |=> (st_ff.sr == {7'h00, HIST_INVALID}))
      else $error("invalid history mark missing");

   AST_FACTORY_WORD: assert property (
      (shift_i.capture && (shift_i.sel == SEL_STATE) &&
       (st_ff.state == ST_FACTORY)) |=>
         (st_ff.sr[38:30] == {7'h00, MS_FACTORY}) &&
         (st_ff.sr[29:24] == 6'h00) &&
         (st_ff.sr[23:0] == $past(boot_addr_o)))
      else $error("factory state word wrong");

   AST_APP_WORD: assert property (
      (shift_i.capture && (shift_i.sel == SEL_STATE) &&
       (st_ff.state != ST_FACTORY)) |=>
         (st_ff.sr[38:30] == {7'h00, MS_APP}) &&
         (st_ff.sr[29] == $past(st_ff.ctl.watchdog_enable)) &&
         (st_ff.sr[28:17] == $past(st_ff.ctl.watchdog_timeout_field)) &&
         (st_ff.sr[16:0] == DOG_LOW))
      else $error("application word one wrong");

   AST_INFO_TWO: assert property (
      (shift_i.capture && (shift_i.sel == SEL_INFO2)) |=>
         (st_ff.sr[38:32] == 7'h00) && (st_ff.sr[29:24] == 6'h00) &&
         (st_ff.sr[23:0] == $past(boot_addr_o)))
      else $error("application word two wrong");

   AST_HISTORY_SHIFT: assert property (
      (st_ff.init && (|cause)) |=> (st_ff.hist2 == $past(st_ff.hist1)))
      else $error("older history record not shifted");

   AST_OSC_OPTION: assert property (
      (st_ff.init && win.fabric) |=>
         (startup_osc_sel_o == $past(st_ff.upd.osc_opt)) &&
         (early_check_o == $past(st_ff.upd.early_done_check_opt)))
      else $error("startup options not taken from update");

   AST_FACTORY_MOVE: assert property (
      (set_s && !st_ff.set_prev) |=> (st_ff.fact_addr == $past(addr_s)))
      else $error("factory address not replaced");

   AST_DOG_USER_ONLY: assert property (
      (st_ff.state != ST_USER) |=>
         $stable(st_ff.dog_cnt) || (st_ff.state == ST_USER))
      else $error("watchdog moved outside user mode");

   COV_FABRIC_LOAD: cover property (
      (st_ff.state == ST_FACTORY) ##1 (st_ff.state == ST_LOADING) ##[1:20]
      (st_ff.state == ST_USER));
   COV_DOG_EXPIRE: cover property (dog_expire);
   COV_EARLY_FAIL: cover property (
      (st_ff.state == ST_LOADING) && st_ff.ctl.early_done_check_opt &&
      early_done_i);
   COV_RESET_TIE: cover property (cause.ext_reset && cause.fabric);
   COV_HISTORY_READ: cover property (
      shift_i.capture && (shift_i.sel == SEL_HIST2) && st_ff.app_seen);
endmodule

// ---- include/ruc_pkg.sv ----
package ruc_pkg;

   // Clock and oscillator rates used to derive the watchdog tick.
   localparam int unsigned CLK_MHZ  = 200;
   localparam int unsigned OSC_MHZ  = 10;
   localparam int unsigned TICK_DIV = CLK_MHZ / OSC_MHZ;

   // Address and count constants.
   localparam logic [23:0] FACT_DEFAULT = 24'h010000;
   localparam logic [23:0] SERIAL_FACT  = 24'h000000;
   localparam logic [16:0] DOG_LOW      = 17'h00008;
   localparam logic [31:0] HIST_INVALID = 32'hFFFFFFFF;

   // Master state codes shown in the status words.
   localparam logic [1:0] MS_FACTORY = 2'h1;
   localparam logic [1:0] MS_APP     = 2'h2;

   // Capture selector codes.
   localparam logic [2:0] SEL_STATE = 3'h0;
   localparam logic [2:0] SEL_INFO2 = 3'h1;
   localparam logic [2:0] SEL_HIST1 = 3'h2;
   localparam logic [2:0] SEL_HIST2 = 3'h3;
   localparam logic [2:0] SEL_CTL   = 3'h4;

   // Synchroniser bank width and idle levels.
   localparam int unsigned SYNC_W   = 28;
   localparam logic [27:0] SYNC_RST = 28'h0000003;
   // Edges after reset release before the strap synchroniser holds the pin.
   localparam logic [4:0]  STRAP_WAIT = 5'h02;

   typedef enum logic [2:0] {
      ST_FACTORY = 3'h1,
      ST_LOADING = 3'h2,
      ST_USER    = 3'h4
   } ruc_state_t;

   typedef struct packed {
      logic        reserved_high_bit;
      logic        early_done_check_opt;
      logic        osc_opt;
      logic        watchdog_enable;
      logic        reserved_low_bit;
      logic [21:0] boot_page_field;
      logic [11:0] watchdog_timeout_field;
   } ruc_ctl_t;

   typedef struct packed {
      logic ext_reset;
      logic crc;
      logic err_line;
      logic watchdog_cause_flag;
      logic fabric;
   } ruc_cause_t;

   typedef struct packed {
      ruc_cause_t  cause;
      logic [1:0]  mstate;
      logic [23:0] boot_addr;
   } ruc_hist_t;

   typedef struct packed {
      logic       shift_en;
      logic       capture;
      logic       update;
      logic       din;
      logic [2:0] sel;
   } ruc_shift_t;

   typedef struct packed {
      ruc_state_t  state;
      logic        init;
      logic        parallel;
      logic        app_seen;
      ruc_ctl_t    ctl;
      ruc_ctl_t    upd;
      logic [23:0] fact_addr;
      logic [23:0] boot_addr;
      ruc_hist_t   hist1;
      ruc_hist_t   hist2;
      logic [28:0] dog_cnt;
      logic [4:0]  tick_cnt;
      logic [38:0] sr;
      logic        ext_prev;
      logic        err_prev;
      logic        set_prev;
      logic        reconfig;
      logic        osc_sel;
      logic        early_chk;
      logic        app_mode;
   } ruc_regs_t;

   localparam ruc_regs_t RUC_RST = '{
      state:     ST_FACTORY,
      fact_addr: FACT_DEFAULT,
      ext_prev:  1'b1,
      err_prev:  1'b1,
      default:   '0
   };

endpackage

// ---- verif/ruc_fabric_model.sv ----
`timescale 1ns/1ps
module ruc_fabric_model (
   // Clock and serial answer
   input  wire logic             clk_i,
   input  wire logic             dout_i,
   // Shift path towards the block
   output ruc_pkg::ruc_shift_t   shift_o
);
   import ruc_pkg::*;

   initial shift_o = '0;

   // Capture one word, then walk it out most significant bit first.
   task automatic read_word(input logic [2:0] sel, output logic [38:0] w);
      @(negedge clk_i);
      shift_o.capture = 1'b1;
      shift_o.sel     = sel;
      @(negedge clk_i);
      shift_o.capture  = 1'b0;
      w[38]            = dout_i;
      shift_o.shift_en = 1'b1;
      for (int i = 37; i >= 0; i--) begin
         @(negedge clk_i);
         w[i] = dout_i;
      end
      shift_o.shift_en = 1'b0;
   endtask

   // The data line is inverted once released, so no stale bit can pass.
   task automatic write_word(input logic [38:0] w);
      for (int i = 38; i >= 0; i--) begin
         @(negedge clk_i);
         shift_o.shift_en = 1'b1;
         shift_o.din      = w[i];
      end
      @(negedge clk_i);
      shift_o.shift_en = 1'b0;
      shift_o.update   = 1'b1;
      shift_o.din      = ~shift_o.din;
      @(negedge clk_i);
      shift_o.update = 1'b0;
   endtask
endmodule

// ---- verif/test_remote_upgrade_ctrl_status.sv ----
`timescale 1ns/1ps
module test_remote_upgrade_ctrl_status;
   import ruc_pkg::*;

   typedef struct packed {
      logic [1:0] kind;
      logic [4:0] cause;
   } ruc_row_t;

   // Factory logic always sets both application options.
   localparam logic [38:0] WU = 39'h3812345000;
   localparam logic [23:0] BW = {WU[33:12], 2'b00};

   logic        clk    = 1'b0;
   logic        nrst   = 1'b0;
   logic        ext_n  = 1'b1;
   logic        err_n  = 1'b1;
   logic        strap  = 1'b0;
   logic        instr  = 1'b0;
   logic [23:0] faddr  = 24'h000000;
   logic        crc    = 1'b0;
   logic        fin    = 1'b0;
   logic        bad    = 1'b0;
   logic        edone  = 1'b0;
   logic        freq   = 1'b0;
   logic        reload = 1'b0;
   ruc_shift_t  sh;
   logic        dout;
   logic        rc;
   logic        osc;
   logic        early;
   logic        app;
   logic [23:0] boot;
   logic [38:0] prev;
   logic [38:0] w;
   logic        seen;
   int          error_cnt  = 0;
   int          n_compared = 0;
   int          cyc        = 0;
   ruc_row_t    rows[3] = '{'{2'h0, 5'h10}, '{2'h1, 5'h04}, '{2'h2, 5'h08}};

   always #2.5 clk = ~clk;

   ruc_upgrade_regs dut (
      .clk_i                     (clk),
      .nrst_i                    (nrst),
      .external_config_reset_n_i (ext_n),
      .config_error_line_n_i     (err_n),
      .parallel_boot_scheme_i    (strap),
      .factory_boot_set_instr_i  (instr),
      .factory_boot_addr_i       (faddr),
      .crc_error_i               (crc),
      .config_finished_pin_i     (fin),
      .early_done_i              (edone),
      .image_bad_i               (bad),
      .shift_i                   (sh),
      .fabric_reconfig_request_i (freq),
      .watchdog_reload_strobe_i  (reload),
      .shift_dout_o              (dout),
      .reconfig_o                (rc),
      .boot_addr_o               (boot),
      .startup_osc_sel_o         (osc),
      .early_check_o             (early),
      .app_mode_o                (app)
   );

   ruc_fabric_model fab (
      .clk_i   (clk),
      .dout_i  (dout),
      .shift_o (sh)
   );

   task automatic chk(input logic [38:0] got, input logic [38:0] exp,
                      input string msg);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t %s got %b", $time, msg, got);
      end
   endtask

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic rd(input logic [2:0] s, input logic [38:0] e,
                     input string m);
      logic [38:0] g;
      fab.read_word(s, g);
      chk(g, e, m);
   endtask

   task automatic wait_rc(input int max, input string msg);
      int n;
      n = 0;
      while (rc !== 1'b1 && n < max) begin
         @(negedge clk);
         n++;
      end
      chk1(rc, 1'b1, msg);
   endtask

   task automatic pulse(input logic c, input logic f);
      @(negedge clk);
      crc  = c;
      freq = f;
      @(negedge clk);
      crc  = 1'b0;
      freq = 1'b0;
   endtask

   // Three edges after release let the pin synchronisers settle.
   task automatic do_reset(input logic s);
      strap = s;
      nrst  = 1'b0;
      repeat (6) @(negedge clk);
      chk1(rc, 1'b0, "reset pulse");
      chk({15'h0, boot}, 39'h0, "reset address");
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      $display("test reset done");
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         error_cnt++;
         $display("FAIL %0t timeout", $time);
         end_sim();
      end
   end

   initial begin
      do_reset(1'b0);
      chk({15'h0, boot}, 39'h0, "serial boot");
      rd(SEL_STATE, {7'h0, MS_FACTORY, 30'h0}, "factory word");
      rd(SEL_HIST1, {7'h0, HIST_INVALID}, "early history");
      fab.write_word(WU);
      rd(SEL_CTL, WU, "update readback");
      pulse(1'b0, 1'b1);
      wait_rc(4, "fabric trigger");
      chk({15'h0, boot}, {15'h0, BW}, "page address");
      chk1(early, 1'b1, "early option");
      chk1(osc, 1'b1, "osc option");
      fin    = 1'b1;
      reload = 1'b1;
      repeat (2) @(negedge clk);
      chk1(app, 1'b1, "user mode");
      chk1(osc, 1'b0, "osc option cleared");
      chk1(early, 1'b0, "early option cleared");
      fin = 1'b0;
      rd(SEL_STATE, {7'h0, MS_APP, 1'b1, 12'h000, DOG_LOW}, "app one");
      rd(SEL_INFO2, {7'h0, MS_APP, 6'h0, BW}, "app two");
      fab.write_word(39'h00000AB000);
      $display("test application done");
      seen = 1'b0;
      repeat (300) begin
         @(negedge clk);
         seen = seen | (rc === 1'b1);
      end
      chk1(seen, 1'b0, "reload holds");
      reload = 1'b0;
      wait_rc(400, "watchdog expiry");
      chk({15'h0, boot}, 39'h0, "factory after error");
      @(negedge clk);
      chk1(app, 1'b0, "left user mode");
      rd(SEL_CTL, WU, "refused update");
      prev = {8'h0, 5'h02, MS_APP, BW};
      rd(SEL_HIST1, prev, "watchdog record");
      rd(SEL_HIST2, {8'h0, 5'h01, MS_FACTORY, 24'h0}, "older");
      $display("test watchdog done");
      for (int i = 0; i < 3; i++) begin
         ext_n = (rows[i].kind != 2'h0);
         err_n = (rows[i].kind != 2'h1);
         crc   = (rows[i].kind == 2'h2);
         @(negedge clk);
         crc = 1'b0;
         wait_rc(12, "cause event");
         ext_n = 1'b1;
         err_n = 1'b1;
         repeat (4) @(negedge clk);
         w = {8'h0, rows[i].cause, MS_FACTORY, 24'h0};
         rd(SEL_HIST1, w, "cause record");
         rd(SEL_HIST2, prev, "shifted record");
         prev = w;
      end
      $display("test causes done");
      pulse(1'b1, 1'b1);
      wait_rc(2, "tie event");
      chk({15'h0, boot}, 39'h0, "tie to factory");
      rd(SEL_HIST1, {8'h0, 5'h08, MS_FACTORY, 24'h0}, "tie record");
      // The pin edge needs two synchroniser edges to meet the fabric pulse.
      ext_n = 1'b0;
      @(negedge clk);
      pulse(1'b0, 1'b1);
      ext_n = 1'b1;
      wait_rc(2, "reset tie");
      rd(SEL_HIST1, {8'h0, 5'h10, MS_FACTORY, 24'h0}, "reset tie");
      pulse(1'b0, 1'b1);
      wait_rc(2, "second trigger");
      @(negedge clk);
      bad = 1'b1;
      @(negedge clk);
      bad = 1'b0;
      wait_rc(4, "bad image");
      chk({15'h0, boot}, 39'h0, "bad image factory");
      pulse(1'b0, 1'b1);
      wait_rc(2, "third trigger");
      @(negedge clk);
      edone = 1'b1;
      @(negedge clk);
      edone = 1'b0;
      wait_rc(4, "early done");
      chk({15'h0, boot}, 39'h0, "early done factory");
      rd(SEL_HIST1, {8'h0, 5'h08, MS_APP, BW}, "early record");
      $display("test tie and early check done");
      do_reset(1'b1);
      chk({15'h0, boot}, {15'h0, FACT_DEFAULT}, "parallel boot");
      faddr = 24'h0ABCD0;
      instr = 1'b1;
      repeat (4) @(negedge clk);
      instr = 1'b0;
      repeat (3) @(negedge clk);
      pulse(1'b1, 1'b0);
      wait_rc(2, "parallel error");
      chk({15'h0, boot}, {15'h0, faddr}, "moved factory");
      $display("test parallel done");
      end_sim();
   end
endmodule
